// ### core/terminal_run_regs.svh
`ifndef TERMINAL_RUN_REGS_SVH
`define TERMINAL_RUN_REGS_SVH
// Sampling tick and timing figures
`define CLK_HZ            32'd125_000_000
`define TICK_US           32'd1000
`define TICK_CYCLES       ((`CLK_HZ / 32'd1_000_000) * `TICK_US)
`define FILT_MAX_MS       16'h0064
`define FILT_DEF_MS       16'h000A
`define READY_MAX_MS      16'h7530
`define READY_DEF_MS      16'h03E8
// Mode codes
`define MODE_2W_FR        3'h0
`define MODE_2W_RUNDIR    3'h1
`define MODE_3W_ONE       3'h2
`define MODE_3W_TWO       3'h3
`define MODE_2W_THREE     3'h4
// Output function codes
`define FN_NONE           4'h0
`define FN_READY          4'h1
`define FN_RUN            4'h2
`define FN_FAULT_ANY      4'h3
`define FN_FAULT_STOP     4'h4
`define FN_FAULT_RUN      4'h5
`define FN_SWING          4'h6
`define FN_TORQUE         4'h7
`define FN_REVERSE        4'h8
`define FN_UPPER          4'h9
`define FN_LOWER_RUN      4'hA
`define FN_LOWER_ALL      4'hB
`define FN_WIN_ONE        4'hC
`define FN_WIN_TWO        4'hD
`define FN_SET_ARRIVE     4'hE
// Status word layout
`define ST_FIRST_DO       0
`define ST_SECOND_DO      1
`define ST_RELAY          2
`define ST_EXP            4
`define ST_VDO            8
`define ST_WIDTH          10
`endif

// ### core/terminal_run_pkg.sv
package terminal_run_pkg;
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_FWD  = 2'b01,
    ST_REV  = 2'b11
  } run_state_t;
endpackage

// ### core/terminal_run_command_logic.sv
`include "terminal_run_regs.svh"
// Function
// - Two-wire mode 2: run switch closed runs, direction picks reverse.
// - Three-wire mode 1: forward press, stop-enable closed, starts forward.
// - Three-wire mode 1: reverse press with stop-enable closed goes reverse.
// - Three-wire mode 1: stop-enable open stops; presses need it closed.
// - Three-wire mode 1: state follows most recent button action.
// - Three-wire mode 2: run press starts, switch picks, enable stops.
// - Filter four base inputs and fast input, 0 to 100 ms, default 10.
// - Protection 1 needs terminal inactive then active after power-on.
// - Input ready time 0 to 30 s, default 1 s.
// - Each virtual input takes a selected bit 0 to 15 of its source.
// - Status word reports ten outputs, 1 means active.
// - First digital output drives function picked by code, default 0.
// - Code 5 running fault, 3 any fault, 4 stopping fault.
// - Mode codes 0,1 two-wire, 2,3 three-wire, 4 third two-wire.
module terminal_run_command_logic
  import terminal_run_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_clk_en,
  input  wire logic [3:0]  i_base_terminal_inputs,
  input  wire logic        i_fast_pulse_input,
  input  wire logic [2:0]  i_run_mode,
  input  wire logic [6:0]  i_filter_ms,
  input  wire logic [14:0] i_ready_ms,
  input  wire logic        i_protect_en,
  input  wire logic [63:0] i_vin_source,
  input  wire logic [15:0] i_vin_select,
  input  wire logic [3:0]  i_first_do_func,
  input  wire logic        i_drive_ready,
  input  wire logic        i_fault_stop,
  input  wire logic        i_fault_run,
  input  wire logic        i_swing_limit,
  input  wire logic        i_torque_limit,
  input  wire logic        i_upper_limit,
  input  wire logic        i_lower_limit,
  input  wire logic        i_freq_window_one,
  input  wire logic        i_freq_window_two,
  input  wire logic        i_set_arrive,
  input  wire logic [8:0]  i_other_outputs,
  output logic [4:0]       o_filtered_inputs,
  output logic [3:0]       o_virtual_inputs,
  output logic             o_run,
  output logic             o_reverse,
  output logic             o_terminal_ready,
  output logic             o_first_digital_output,
  output logic [9:0]       o_output_status
);

  //////////////////////////////////////////////////////////////////////////
  // Millisecond tick shared by filter and ready timer
  logic [16:0] tick_cnt;
  logic        tick;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
    begin
      tick_cnt <= 17'h0_0000;
      tick     <= 1'b0;
    end
    else if (i_clk_en)
    begin
      tick <= (tick_cnt == 17'(`TICK_CYCLES - 1));
      if (tick_cnt == 17'(`TICK_CYCLES - 1))
        tick_cnt <= 17'h0_0000;
      else
        tick_cnt <= tick_cnt + 17'h0_0001;
    end

  //////////////////////////////////////////////////////////////////////////
  // Input filters, one per terminal
  logic [4:0] raw_in;
  assign raw_in = {i_fast_pulse_input, i_base_terminal_inputs};
  logic [6:0] filt_lim;
  // Out-of-range settings are clamped rather than rejected
  assign filt_lim = (7'(`FILT_MAX_MS) < i_filter_ms) ? 7'(`FILT_MAX_MS)
                                                     : i_filter_ms;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_filt
      logic [6:0] cnt;
      always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst)
        begin
          cnt                  <= 7'h00;
          o_filtered_inputs[g] <= 1'b0;
        end
        else if (i_clk_en)
        begin
          if (raw_in[g] == o_filtered_inputs[g])
            cnt <= 7'h00;
          else if (filt_lim == 7'h00 || (tick && cnt + 7'h01 >= filt_lim))
          begin
            o_filtered_inputs[g] <= raw_in[g];
            cnt                  <= 7'h00;
          end
          else if (tick)
            cnt <= cnt + 7'h01;
        end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Ready time after reset; commands ignored until it expires
  logic [14:0] ready_cnt;
  logic [14:0] ready_lim;
  assign ready_lim = (15'(`READY_MAX_MS) < i_ready_ms) ? 15'(`READY_MAX_MS)
                                                       : i_ready_ms;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
    begin
      ready_cnt        <= 15'h0000;
      o_terminal_ready <= 1'b0;
    end
    else if (i_clk_en && !o_terminal_ready)
    begin
      if (ready_cnt >= ready_lim)
        o_terminal_ready <= 1'b1;
      else if (tick)
        ready_cnt <= ready_cnt + 15'h0001;
    end

  //////////////////////////////////////////////////////////////////////////
  // Run command decode
  logic t0, t1, t2, t0_q, t1_q, cmd_any;
  assign t0 = o_filtered_inputs[0];
  assign t1 = o_filtered_inputs[1];
  assign t2 = o_filtered_inputs[2];
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
    begin
      t0_q <= 1'b0;
      t1_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      t0_q <= t0;
      t1_q <= t1;
    end

  // Protection latch: run terminals must be seen inactive after ready
  logic armed;
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
      armed <= 1'b0;
    else if (i_clk_en && o_terminal_ready && (!i_protect_en || !cmd_any))
      armed <= 1'b1;

  run_state_t state, next_state;
  always_comb
  begin
    next_state = state;
    cmd_any    = t0 | t1;
    unique case (i_run_mode)
      `MODE_2W_FR:
        next_state = (t0 ^ t1) ? (t0 ? ST_FWD : ST_REV) : ST_STOP;
      `MODE_2W_RUNDIR, `MODE_2W_THREE:
      begin
        cmd_any    = t0;
        next_state = t0 ? (t1 ? ST_REV : ST_FWD) : ST_STOP;
      end
      `MODE_3W_ONE:
      begin
        if (!t2)
          next_state = ST_STOP;
        else if (t1 && !t1_q)
          next_state = ST_REV;
        else if (t0 && !t0_q)
          next_state = ST_FWD;
      end
      `MODE_3W_TWO:
      begin
        cmd_any = t0;
        if (!t2)
          next_state = ST_STOP;
        else if (t0 && !t0_q)
          next_state = t1 ? ST_REV : ST_FWD;
        else if (state != ST_STOP)
          next_state = t1 ? ST_REV : ST_FWD;
      end
      default:
        next_state = ST_STOP;
    endcase
    if (!armed)
      next_state = ST_STOP;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
    begin
      state     <= ST_STOP;
      o_run     <= 1'b0;
      o_reverse <= 1'b0;
    end
    else if (i_clk_en)
    begin
      state     <= next_state;
      o_run     <= (next_state != ST_STOP);
      o_reverse <= (next_state == ST_REV);
    end

  //////////////////////////////////////////////////////////////////////////
  // Virtual inputs: source word per input, nibble of selector picks bit
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_vin
      always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst)
          o_virtual_inputs[g] <= 1'b0;
        else if (i_clk_en)
          o_virtual_inputs[g] <=
            i_vin_source[16*g + i_vin_select[4*g +: 4]];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // First digital output function select and status word
  logic fn_out;
  always_comb
  begin
    unique case (i_first_do_func)
      `FN_READY:      fn_out = i_drive_ready;
      `FN_RUN:        fn_out = o_run;
      `FN_FAULT_ANY:  fn_out = i_fault_stop | i_fault_run;
      `FN_FAULT_STOP: fn_out = i_fault_stop;
      `FN_FAULT_RUN:  fn_out = i_fault_run;
      `FN_SWING:      fn_out = i_swing_limit;
      `FN_TORQUE:     fn_out = i_torque_limit;
      `FN_REVERSE:    fn_out = o_run & o_reverse;
      `FN_UPPER:      fn_out = i_upper_limit;
      // Lower limit code 10 is masked while stopped
      `FN_LOWER_RUN:  fn_out = i_lower_limit & o_run;
      `FN_LOWER_ALL:  fn_out = i_lower_limit;
      `FN_WIN_ONE:    fn_out = i_freq_window_one;
      `FN_WIN_TWO:    fn_out = i_freq_window_two;
      `FN_SET_ARRIVE: fn_out = i_set_arrive;
      default:        fn_out = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
    begin
      o_first_digital_output <= 1'b0;
      o_output_status        <= 10'h000;
    end
    else if (i_clk_en)
    begin
      o_first_digital_output <= fn_out;
      o_output_status        <= {i_other_outputs, fn_out};
    end

endmodule // terminal_run_command_logic

// ### tb/terminal_run_checker.sv
`include "terminal_run_regs.svh"
module terminal_run_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_clk_en,
  input wire logic [2:0]  i_run_mode,
  input wire logic [63:0] i_vin_source,
  input wire logic [15:0] i_vin_select,
  input wire logic [3:0]  i_first_do_func,
  input wire logic        i_fault_stop,
  input wire logic        i_fault_run,
  input wire logic [8:0]  i_other_outputs,
  input wire logic [4:0]  o_filtered_inputs,
  input wire logic [3:0]  o_virtual_inputs,
  input wire logic        o_run,
  input wire logic        o_first_digital_output,
  input wire logic [9:0]  o_output_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit the fourth virtual input should pick this cycle
  logic vin_pick;
  assign vin_pick = i_vin_source[48 + i_vin_select[15:12]];
  // A frozen cycle owes nothing, so clock enable low also disables
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst || !i_clk_en);
  AST_RUN_OFF: assert property (
    i_run_mode == `MODE_2W_RUNDIR && !o_filtered_inputs[0] |=> !o_run)
    else $error("run without run switch");
  AST_ENABLE_ONE: assert property (
    i_run_mode == `MODE_3W_ONE && !o_filtered_inputs[2] |=> !o_run)
    else $error("run with enable open");
  AST_ENABLE_TWO: assert property (
    i_run_mode == `MODE_3W_TWO && !o_filtered_inputs[2] |=> !o_run)
    else $error("run with enable open");
  AST_BAD_MODE: assert property (
    i_run_mode > 3'h4 |=> !o_run)
    else $error("run in unknown mode");
  AST_VIN: assert property (
    1'b1 |=> o_virtual_inputs[3] == $past(vin_pick))
    else $error("virtual input bit wrong");
  AST_STATUS: assert property (
    1'b1 |=> o_output_status[9:1] == $past(i_other_outputs))
    else $error("status word wrong");
  AST_FAULT_ANY: assert property (
    i_first_do_func == `FN_FAULT_ANY |=>
      o_first_digital_output == ($past(i_fault_stop) | $past(i_fault_run)))
    else $error("any fault output wrong");
  AST_NO_FUNC: assert property (
    i_first_do_func == `FN_NONE |=> !o_first_digital_output)
    else $error("output active with no function");
  cover property (o_run && i_run_mode == `MODE_3W_ONE);
  cover property ($rose(o_run) && i_run_mode == `MODE_3W_TWO);
  cover property (o_first_digital_output && i_first_do_func == `FN_FAULT_RUN);
endmodule // terminal_run_checker
bind terminal_run_command_logic terminal_run_checker CHK (.*);

// ### tb/terminal_switches.sv
module terminal_switches (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_req,
  output logic [3:0]      o_terms = 4'h0,
  output logic            o_fast = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts move on the falling edge, clear of the sampling edge
  always @(negedge i_clk)
  begin
    o_terms <= i_req[3:0];
    o_fast  <= i_req[4];
  end
endmodule // terminal_switches

// ### tb/tb.sv
`include "terminal_run_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys, i_nrst, i_clk_en, i_protect_en, i_fast_pulse_input;
  logic [3:0]  i_base_terminal_inputs, i_first_do_func, o_virtual_inputs;
  logic [2:0]  i_run_mode;
  logic [6:0]  i_filter_ms;
  logic [14:0] i_ready_ms;
  logic [63:0] i_vin_source;
  logic [15:0] i_vin_select, v;
  logic        i_drive_ready, i_fault_stop, i_fault_run, i_swing_limit;
  logic        i_torque_limit, i_upper_limit, i_lower_limit, i_set_arrive;
  logic        i_freq_window_one, i_freq_window_two, m_run, m_rev, pick;
  logic [8:0]  i_other_outputs;
  logic [4:0]  o_filtered_inputs, sw_req, prev;
  logic        o_run, o_reverse, o_terminal_ready, o_first_digital_output;
  logic [9:0]  o_output_status;
  logic [31:0] seed = 32'h0000_005A;
  int          num_errors = 0;
  int          comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  terminal_run_command_logic DUT (.*);
  terminal_switches SW (
    .i_clk   (i_clk_sys),
    .i_req   (sw_req),
    .o_terms (i_base_terminal_inputs),
    .o_fast  (i_fast_pulse_input)
  );
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Model of the run state; filter time zero, so edges seen one to one
  task automatic apply(input logic [4:0] t);
    logic r0, r1;
    r0 = t[0] & ~prev[0];
    r1 = t[1] & ~prev[1];
    case (i_run_mode)
      `MODE_2W_FR:  m_run = t[0] ^ t[1];
      `MODE_3W_ONE: m_run = t[2] & (r0 | r1 | m_run);
      `MODE_3W_TWO: m_run = t[2] & (r0 | m_run);
      `MODE_2W_RUNDIR, `MODE_2W_THREE: m_run = t[0];
      default:      m_run = 1'b0;
    endcase
    m_rev = (i_run_mode == `MODE_3W_ONE) ? r1 | (m_rev & ~r0) : t[1];
    m_rev = m_rev & m_run;
    prev = t;
    sw_req <= t;
    repeat (5) @(negedge i_clk_sys);
    check({o_run, o_reverse}, {m_run, m_rev});
    check(o_filtered_inputs, t);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // About 800 cycles are needed; the limit leaves ample slack
    #30us;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    {i_clk_en, i_nrst, i_protect_en, i_run_mode} = {3'b101, `MODE_2W_RUNDIR};
    {i_filter_ms, i_ready_ms, i_vin_source, i_vin_select} = '0;
    {i_drive_ready, i_fault_stop, i_fault_run, i_swing_limit, i_torque_limit,
     i_upper_limit, i_lower_limit, i_freq_window_one, i_freq_window_two,
     i_set_arrive, i_other_outputs, i_first_do_func} = '0;
    {sw_req, prev, m_run, m_rev} = {5'h01, 5'h01, 2'b00};
    repeat (12) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    check(o_terminal_ready, 1'b1);
    check(o_run, 1'b0);
    apply(5'h00);
    apply(5'h01);
    $display("protection test done");
    i_protect_en = 1'b0;
    for (int m = 0; m < 8; m++)
    begin
      i_run_mode = m[2:0];
      repeat (16) apply(5'(rnd()));
      apply(5'h00);
      $display("mode %0d test done", m);
    end
    i_run_mode = `MODE_2W_RUNDIR;
    // Clock enable low must freeze filter and run state alike
    i_clk_en = 1'b0;
    sw_req <= 5'h01;
    repeat (5) @(negedge i_clk_sys);
    check(o_run, 1'b0);
    check(o_filtered_inputs, 5'h00);
    i_clk_en = 1'b1;
    apply(5'h01);
    // One ms filter: no tick falls in this short run, so nothing passes
    i_filter_ms = 7'h01;
    sw_req <= 5'h11;
    repeat (20) @(negedge i_clk_sys);
    check(o_filtered_inputs, 5'h01);
    i_filter_ms = 7'h00;
    apply(5'h11);
    $display("filter and freeze test done");
    apply(5'h03);
    for (int f = 0; f < 16; f++)
    begin
      {i_drive_ready, i_fault_stop, i_fault_run, i_swing_limit, i_torque_limit,
       i_upper_limit, i_lower_limit, i_freq_window_one, i_freq_window_two,
       i_set_arrive, i_other_outputs} = 19'(rnd());
      {i_vin_source, i_vin_select} = 80'({rnd(), rnd(), rnd()});
      i_first_do_func = f[3:0];
      v = {1'b0, i_set_arrive, i_freq_window_two, i_freq_window_one,
           i_lower_limit, i_lower_limit & m_run, i_upper_limit, m_rev,
           i_torque_limit, i_swing_limit, i_fault_run, i_fault_stop,
           i_fault_stop | i_fault_run, m_run, i_drive_ready, 1'b0};
      repeat (3) @(negedge i_clk_sys);
      check(o_first_digital_output, v[f]);
      check(o_output_status, {i_other_outputs, v[f]});
      for (int g = 0; g < 4; g++)
      begin
        pick = i_vin_source[16*g+i_vin_select[4*g+:4]];
        check(o_virtual_inputs[g], pick);
      end
    end
    $display("output function test done");
    end_of_test();
  end
endmodule // tb
